// ---- power_mode_pkg.sv ----
// Package for the power mode and power domain controller.
// Assumes a single 10 MHz system clock and a 32-bit APB slave.
package power_mode_pkg;

    // APB register offsets (byte addresses)
    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_DOMAIN_EN = 12'h004;
    localparam logic [11:0] ADDR_STATUS    = 12'h008;
    localparam logic [11:0] ADDR_WORDCNT   = 12'h00C;
    localparam logic [11:0] ADDR_RETAIN    = 12'h010;

    // CTRL register fields
    localparam int CTRL_RETAIN_SYSRAM_BIT = 0;
    localparam int CTRL_DEEP_SLEEP_BIT    = 2;

    // DOMAIN_EN register fields
    localparam int EN_PERIPH_BIT = 0;
    localparam int EN_RADIO_BIT  = 1;
    localparam int EN_RRAM_LSB   = 4;

    // RETAIN register fields
    localparam int RET_MAP_LSB    = 0;
    localparam int RET_MAP_W      = 2;
    localparam int RET_RADIO_LSB  = 8;
    localparam int RET_RADIO_W    = 16;
    localparam int RET_FREEZE_BIT = 24;

    // Reset values
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0] DOMAIN_EN_RESET = 32'h0000_0003;

    // Retention bank sizes in kB
    localparam int RRAM_LINES = 4;
    localparam int RRAM_KB_A  = 2;
    localparam int RRAM_KB_B  = 3;
    localparam int RRAM_KB_C  = 2;
    localparam int RRAM_KB_D  = 1;
    localparam int SYSRAM_KB  = 42;

    // Power-up and power-down settling times
    localparam int CLK_MHZ          = 10;
    localparam int SETTLE_NS        = 1000;
    localparam int SETTLE_CYCLES    = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_W         = 8;

    typedef enum logic [4:0] {
        ST_ACTIVE   = 5'b00001,
        ST_SLEEP    = 5'b00010,
        ST_GATE_OFF = 5'b00100,
        ST_GATED    = 5'b01000,
        ST_RESTORE  = 5'b10000
    } power_state_e;

    // Switch controls for all domains
    typedef struct packed {
        logic                  system_domain;
        logic                  debug_domain;
        logic                  peripheral_domain;
        logic                  radio_domain;
        logic                  system_ram_power_line;
        logic [RRAM_LINES-1:0] retention_ram_lines;
        logic                  analog_on;
    } domain_power_s;

    // Values retained across sleep
    typedef struct packed {
        logic [RET_RADIO_W-1:0] radio_control_reg;
        logic                   debug_freeze_enable;
        logic [RET_MAP_W-1:0]   exchange_memory_map;
    } retained_s;

endpackage : power_mode_pkg

// ---- sleep_power_domain_control.sv ----
// Power mode and power domain controller with APB register access.
// Assumes the processor sleep and wake signals are synchronous.
// Assumes software programs the domain enables before a gated mode.
`timescale 1ns/10ps
`default_nettype none

module sleep_power_domain_control
    import power_mode_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYCLES
) (
    input  wire logic                         clk_sys_i,
    input  wire logic                         reset_n_i,
    input  wire logic                         psel_i,
    input  wire logic                         penable_i,
    input  wire logic                         pwrite_i,
    input  wire logic [11:0]                  paddr_i,
    input  wire logic [31:0]                  pwdata_i,
    output logic      [31:0]                  prdata_o,
    output logic                              pready_o,
    output logic                              pslverr_o,
    input  wire logic                         cpu_sleep_i,
    input  wire logic                         wake_event_i,
    output power_mode_pkg::domain_power_s     power_o,
    output power_mode_pkg::retained_s         retained_o,
    output logic                              cpu_release_o,
    output logic                              mirror_needed_o,
    output logic                              periph_reset_o
);
    import power_mode_pkg::*;

    power_state_e           state_q, state_d;
    logic [31:0]            ctrl_q;
    logic [31:0]            domain_en_q;
    logic [31:0]            wordcnt_q;
    logic                   wordcnt_loaded_q;
    retained_s              retain_q;
    logic [SETTLE_W-1:0]    cnt_q, cnt_d;
    logic                   deep_q, deep_d;
    domain_power_s          power_d;
    logic [31:0]            rdata_d;
    logic                   periph_off_q;

    // Gating states hold core, debug and analog off
    function automatic logic is_gating(input power_state_e s);
        is_gating = (s == ST_GATE_OFF) || (s == ST_GATED);
    endfunction : is_gating

    // Running states let the processor execute
    function automatic logic is_running(input power_state_e s);
        is_running = (s == ST_ACTIVE) || (s == ST_SLEEP);
    endfunction : is_running

    // Register decode
    wire logic wr_en   = psel_i & penable_i & pwrite_i;
    wire logic setup_ph = psel_i & ~penable_i;
    wire logic hit_ctl = (paddr_i == ADDR_CTRL);
    wire logic hit_en  = (paddr_i == ADDR_DOMAIN_EN);
    wire logic hit_st  = (paddr_i == ADDR_STATUS);
    wire logic hit_wc  = (paddr_i == ADDR_WORDCNT);
    wire logic hit_ret = (paddr_i == ADDR_RETAIN);
    wire logic mapped  = hit_ctl | hit_en | hit_st | hit_wc | hit_ret;

    // Write strobes per register
    wire logic wr_ctl  = wr_en & hit_ctl;
    wire logic wr_dom  = wr_en & hit_en;
    wire logic wr_wc   = wr_en & hit_wc & ~wordcnt_loaded_q;
    wire logic wr_ret  = wr_en & hit_ret;

    // Retained field slices of the write data
    wire logic [RET_MAP_W-1:0]   ret_map_w   =
        pwdata_i[RET_MAP_LSB +: RET_MAP_W];
    wire logic [RET_RADIO_W-1:0] ret_radio_w =
        pwdata_i[RET_RADIO_LSB +: RET_RADIO_W];
    wire logic                   ret_frz_w   = pwdata_i[RET_FREEZE_BIT];

    wire logic deep_sleep_request_bit  = ctrl_q[CTRL_DEEP_SLEEP_BIT];
    wire logic retain_system_ram_bit = ctrl_q[CTRL_RETAIN_SYSRAM_BIT];
    wire logic settled    = (cnt_q == SETTLE_W'(SETTLE - 1));
    wire logic [SETTLE_W-1:0] cnt_inc = cnt_q + SETTLE_W'(1);

    // Mode requests from the processor
    wire logic req_gate   = cpu_sleep_i & deep_sleep_request_bit;
    wire logic req_sleep  = cpu_sleep_i & ~deep_sleep_request_bit;
    wire logic sleep_exit = wake_event_i | ~cpu_sleep_i;
    wire logic deep_pick  = ~retain_system_ram_bit;

    wire logic [RRAM_LINES-1:0] rram_en;

    // One switch per retention bank, each independent
    for (genvar gi = 0; gi < RRAM_LINES; gi++) begin : g_rram
        assign rram_en[gi] = domain_en_q[EN_RRAM_LSB + gi];
    end

    wire logic gated_now    = (state_q == ST_GATED);
    wire logic gating_now   = is_gating(state_q);
    wire logic restore_done = (state_q == ST_RESTORE) & settled;

    // Status and retained fields as read back
    wire logic [31:0] status_word = {26'h0, deep_q, state_q};
    wire logic [31:0] retain_word = {7'h0, retain_q.debug_freeze_enable,
                                     retain_q.radio_control_reg,
                                     6'h0, retain_q.exchange_memory_map};

    // Next state of the power sequencer
    always_comb begin
        state_d = state_q;
        cnt_d   = '0;
        deep_d  = deep_q;
        case (state_q)
            ST_ACTIVE: begin
                if (req_gate) begin
                    state_d = ST_GATE_OFF;
                    deep_d  = deep_pick;
                end else if (req_sleep) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (sleep_exit) begin
                    state_d = ST_ACTIVE;
                end
            end
            ST_GATE_OFF: begin
                cnt_d = cnt_inc;
                if (settled) begin
                    state_d = ST_GATED;
                end
            end
            ST_GATED: begin
                if (wake_event_i) begin
                    state_d = ST_RESTORE;
                end
            end
            ST_RESTORE: begin
                cnt_d = cnt_inc;
                if (settled) begin
                    state_d = ST_ACTIVE;
                end
            end
            default: begin
                state_d = ST_ACTIVE;
            end
        endcase
    end

    // Domain switch settings per state
    always_comb begin
        power_d = '0;
        power_d.retention_ram_lines = rram_en;
        power_d.peripheral_domain   = domain_en_q[EN_PERIPH_BIT];
        power_d.radio_domain        = domain_en_q[EN_RADIO_BIT];
        if (gating_now) begin
            power_d.system_domain         = 1'b0;
            power_d.debug_domain          = 1'b0;
            power_d.analog_on             = 1'b0;
            power_d.system_ram_power_line = ~deep_q;
            if (gated_now) begin
                power_d.peripheral_domain = 1'b0;
                power_d.radio_domain      = 1'b0;
            end
        end else begin
            power_d.system_domain         = 1'b1;
            power_d.debug_domain          = 1'b1;
            power_d.analog_on             = 1'b1;
            power_d.system_ram_power_line = 1'b1;
        end
    end

    // Read data selection
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_ctl) begin
            rdata_d = ctrl_q;
        end else if (hit_en) begin
            rdata_d = domain_en_q;
        end else if (hit_st) begin
            rdata_d = status_word;
        end else if (hit_wc) begin
            rdata_d = wordcnt_q;
        end else if (hit_ret) begin
            rdata_d = retain_word;
        end
    end

    // Sequencer state
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ST_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    // Settle counter and chosen sleep depth
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q  <= '0;
            deep_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            deep_q <= deep_d;
        end
    end

    // Control register lives in the always-on domain
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_ctl) begin
            ctrl_q <= pwdata_i;
        end else if (restore_done) begin
            ctrl_q[CTRL_DEEP_SLEEP_BIT] <= 1'b0;
        end
    end

    // Domain enables, programmed before a gated mode
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            domain_en_q <= DOMAIN_EN_RESET;
        end else if (wr_dom) begin
            domain_en_q <= pwdata_i;
        end
    end

    // Word count written once, held through every sleep mode
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wordcnt_q        <= 32'h0000_0000;
            wordcnt_loaded_q <= 1'b0;
        end else if (wr_wc) begin
            wordcnt_q        <= pwdata_i;
            wordcnt_loaded_q <= 1'b1;
        end
    end

    // Retained fields; survive gating of their home domains
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            retain_q <= '0;
        end else if (wr_ret) begin
            retain_q.exchange_memory_map <= ret_map_w;
            retain_q.radio_control_reg   <= ret_radio_w;
            retain_q.debug_freeze_enable <= ret_frz_w;
        end
    end

    // Next values of the registered outputs
    wire logic        cpu_run_d  = is_running(state_d);
    wire logic        mirror_set = gated_now & deep_q;
    wire logic        mirror_clr = (state_q == ST_ACTIVE);
    wire logic        pready_d   = setup_ph;
    wire logic        pslverr_d  = setup_ph & ~mapped;
    wire logic [31:0] prdata_d   = (setup_ph & ~pwrite_i) ? rdata_d
                                                          : 32'h0000_0000;

    // Domain switches
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            power_o <= '0;
        end else begin
            power_o <= power_d;
        end
    end

    // Retained copy seen by the gated domains
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            retained_o <= '0;
        end else begin
            retained_o <= retain_q;
        end
    end

    // Processor release, only once core, debug, system RAM and analog are powered
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cpu_release_o <= 1'b0;
        end else begin
            cpu_release_o <= cpu_run_d;
        end
    end

    // Copy request; set wins over clear
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mirror_needed_o <= 1'b0;
        end else if (mirror_set) begin
            mirror_needed_o <= 1'b1;
        end else if (mirror_clr) begin
            mirror_needed_o <= 1'b0;
        end
    end

    // Peripheral reset trails power off by one cycle
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            periph_off_q   <= 1'b0;
            periph_reset_o <= 1'b1;
        end else begin
            periph_off_q   <= ~power_d.peripheral_domain;
            periph_reset_o <= periph_off_q;
        end
    end

    // APB answer, zero wait states
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            prdata_o  <= prdata_d;
            pready_o  <= pready_d;
            pslverr_o <= pslverr_d;
        end
    end

endmodule : sleep_power_domain_control

`default_nettype wire

// ---- sleep_power_domain_control_chk.sv ----
// Port checker for the power mode controller.
// Assumes it is bound onto the controller's top module.
`timescale 1ns/10ps
`default_nettype none
module sleep_power_domain_control_chk
    import power_mode_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYCLES
) (
    input wire logic                          clk_sys_i,
    input wire logic                          reset_n_i,
    input wire logic                          psel_i,
    input wire logic                          penable_i,
    input wire logic                          pwrite_i,
    input wire logic                          wake_event_i,
    input wire power_mode_pkg::domain_power_s power_o,
    input wire power_mode_pkg::retained_s     retained_o,
    input wire logic                          cpu_release_o,
    input wire logic                          mirror_needed_o,
    input wire logic                          periph_reset_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    logic wr_q, wr_qq;
    // Delayed write strobes
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_q  <= 1'b0;
            wr_qq <= 1'b0;
        end else begin
            wr_q  <= psel_i & penable_i & pwrite_i;
            wr_qq <= wr_q;
        end
    end
    sequence gate_entry;
        $fell(power_o.analog_on);
    endsequence
    sequence wake_gated;
        $rose(wake_event_i) && !power_o.system_domain;
    endsequence
    a_gate_off_core: assert property (
        !power_o.analog_on |-> !power_o.system_domain
            && !power_o.debug_domain) else $error("core on while gated");
    a_entry_halts: assert property (
        gate_entry |-> !cpu_release_o) else $error("cpu runs at gating");
    a_release_powered: assert property (
        cpu_release_o |-> power_o.system_domain && power_o.debug_domain
            && power_o.system_ram_power_line && power_o.analog_on)
        else $error("cpu runs unpowered");
    a_wake_bound: assert property (
        wake_gated |-> ##[1:40] cpu_release_o) else $error("no wake");
    a_periph_reset: assert property (
        $fell(power_o.peripheral_domain) |-> ##[1:2] periph_reset_o)
        else $error("peripheral reset missing");
    a_retain_hold: assert property (
        !cpu_release_o && !$past(cpu_release_o) |-> $stable(retained_o))
        else $error("retained value lost");
    a_lines_by_write: assert property (
        $changed(power_o.retention_ram_lines) |-> wr_q || wr_qq)
        else $error("retention line moved alone");
    a_deep_mirror: assert property (
        $rose(mirror_needed_o) |-> !power_o.system_ram_power_line
            && !power_o.peripheral_domain) else $error("deep sleep power");
endmodule : sleep_power_domain_control_chk
bind sleep_power_domain_control sleep_power_domain_control_chk #(
    .SETTLE(SETTLE)) chk_u (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i),
    .wake_event_i(wake_event_i), .power_o(power_o),
    .retained_o(retained_o), .cpu_release_o(cpu_release_o),
    .mirror_needed_o(mirror_needed_o), .periph_reset_o(periph_reset_o));
`default_nettype wire

// ---- sleep_power_domain_control_bench.sv ----
// Self-checking bench for the power mode controller.
// Assumes the checker file is compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module sleep_power_domain_control_bench;
    import power_mode_pkg::*;
    logic          clk_sys_i, reset_n_i, psel_i, penable_i, pwrite_i;
    logic          pready_o, pslverr_o, cpu_sleep_i, wake_event_i, err;
    logic          cpu_release_o, mirror_needed_o, periph_reset_o;
    logic [11:0]   paddr_i;
    logic [31:0]   pwdata_i, prdata_o, rd;
    domain_power_s power_o;
    retained_s     retained_o;
    int            n_mismatch, tests_run;
    sleep_power_domain_control #(.SETTLE(3)) dut_u (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .cpu_sleep_i(cpu_sleep_i),
        .wake_event_i(wake_event_i), .power_o(power_o),
        .retained_o(retained_o), .cpu_release_o(cpu_release_o),
        .mirror_needed_o(mirror_needed_o), .periph_reset_o(periph_reset_o));
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    task automatic close_out;
        if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; read data and error kept in rd and err
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            close_out();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : apb
    // Bounded wait on cpu release or peripheral power
    task automatic wait_on(input bit rel, input logic v);
        int k;
        k = 0;
        while ((rel ? cpu_release_o : power_o.peripheral_domain) !== v) begin
            @(posedge clk_sys_i);
            k++;
            if (k > 50) begin
                n_mismatch++;
                close_out();
            end
        end
    endtask : wait_on
    initial begin
        {psel_i, penable_i, pwrite_i, cpu_sleep_i, wake_event_i} = 5'h00;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        reset_n_i = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (8) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        check(32'(power_o), {22'h0, 10'b11111_0000_1});
        check(32'(cpu_release_o), 32'h1);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, CTRL_RESET);
        apb(1'b0, ADDR_DOMAIN_EN, 32'h0);
        check(rd, DOMAIN_EN_RESET);
        for (int i = 0; i < RRAM_LINES; i++) begin
            apb(1'b1, ADDR_DOMAIN_EN, 32'h3 | (32'h10 << i));
            @(posedge clk_sys_i);
            check(32'(power_o.retention_ram_lines), 32'h1 << i);
        end
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        apb(1'b1, ADDR_WORDCNT, 32'h2A);
        apb(1'b1, ADDR_WORDCNT, 32'h55);
        apb(1'b0, ADDR_WORDCNT, 32'h0);
        check(rd, 32'h2A);
        apb(1'b1, ADDR_RETAIN, 32'h01AB_CD02);
        @(posedge clk_sys_i);
        check(32'(retained_o), {13'h0, 16'hABCD, 3'b110});
        apb(1'b1, ADDR_CTRL, 32'h0);
        cpu_sleep_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        check(32'(power_o), {22'h0, 10'b11111_1000_1});
        cpu_sleep_i <= 1'b0;
        wait_on(1'b1, 1'b1);
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, ADDR_DOMAIN_EN, 32'h23);
            apb(1'b1, ADDR_CTRL, m ? 32'h4 : 32'h5);
            cpu_sleep_i <= 1'b1;
            @(posedge clk_sys_i);
            cpu_sleep_i <= 1'b0;
            wait_on(1'b0, 1'b0);
            repeat (3) @(posedge clk_sys_i);
            check(32'(power_o), {22'h0, 4'h0, m == 0, 5'b0010_0});
            check(32'(mirror_needed_o), 32'(m));
            check(32'(periph_reset_o), 32'h1);
            check(32'(retained_o), {13'h0, 16'hABCD, 3'b110});
            apb(1'b0, ADDR_STATUS, 32'h0);
            check(rd, {26'h0, m == 1, 5'b01000});
            wake_event_i <= 1'b1;
            @(posedge clk_sys_i);
            wake_event_i <= 1'b0;
            wait_on(1'b1, 1'b1);
            check(32'(power_o), {22'h0, 10'b11111_0010_1});
            apb(1'b0, ADDR_CTRL, 32'h0);
            check(rd, m ? 32'h0 : 32'h1);
            apb(1'b0, ADDR_WORDCNT, 32'h0);
            check(rd, 32'h2A);
        end
        close_out();
    end
endmodule : sleep_power_domain_control_bench
`default_nettype wire
